// >>> burner_params.svh
// Named constants for the burner ignition sequencer
`ifndef BURNER_PARAMS_SVH
`define BURNER_PARAMS_SVH

// System clock rate and time base
`define CLK_HZ                 100000000
`define MS_PER_S               1000

// Sequence times in milliseconds
`define WAIT_DELAY_MS          5000
`define PRE_IGNITION_MS        10000
`define FLAME_PROVING_LIMIT_MS 10000
`define STABILISATION_MS       5000

// Register byte addresses
`define REG_CTRL               32'h0000_0000
`define REG_STATUS             32'h0000_0004
`define REG_IRQ_STAT           32'h0000_0008
`define REG_IRQ_MASK           32'h0000_000C

// Control register fields and reset value
`define CTRL_ENABLE_BIT        0
`define CTRL_PRESS_BIT         1
`define CTRL_RESET             32'h0000_0001
`define CTRL_STORED_MASK       32'h0000_0001

// Status register fields
`define STAT_STATE_LSB         0
`define STAT_RETRY_BIT         3
`define STAT_ACT_LSB           8

// Interrupt bits
`define IRQ_WIDTH              3
`define IRQ_LOCK_BIT           0
`define IRQ_LOSS_BIT           1
`define IRQ_RUN_BIT            2
`define IRQ_RESET              3'h0

// Actuator pattern held in reset: lockout lamp only
`define ACT_LOCK_RESET         6'h20

`endif

// >>> bis_pkg.sv
// Types shared by the burner ignition sequencer files
package bis_pkg;

  typedef enum logic [2:0] {
    S_LOCK,
    S_IDLE,
    S_WAIT,
    S_SPARK,
    S_PROVE,
    S_STAB,
    S_RUN
  } seq_state_type;

  typedef struct packed {
    logic lamp;
    logic high;
    logic low;
    logic safety;
    logic pilot;
    logic spark;
  } actuator_type;

endpackage : bis_pkg

// >>> seq_timer.sv
// Down-counting interval timer used for each sequence step
`timescale 1ns/100ps
`default_nettype none

module seq_timer #(
  parameter int TW = 32
) (
  input  wire logic          clk_sys_in,
  input  wire logic          nrst_in,
  input  wire logic          load_in,
  input  wire logic [TW-1:0] value_in,
  output logic               done_out
);

  logic [TW-1:0] count;
  logic [TW-1:0] next_count;

  // Loading value N makes done rise after N further edges
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = value_in;
    end else if (count != '0) begin
      next_count = count - TW'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_out = (count == '0);

endmodule : seq_timer

`default_nettype wire

// >>> burner_ignition_sequencer.sv
// Burner ignition sequencer with AHB-Lite registers and interrupt
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "burner_params.svh"

module burner_ignition_sequencer #(
  parameter int          TW            = 32,
  parameter logic [TW-1:0] WAIT_CYCLES  =
    TW'(`WAIT_DELAY_MS * (`CLK_HZ / `MS_PER_S)),
  parameter logic [TW-1:0] PREIGN_CYCLES =
    TW'(`PRE_IGNITION_MS * (`CLK_HZ / `MS_PER_S)),
  parameter logic [TW-1:0] PROVE_CYCLES =
    TW'(`FLAME_PROVING_LIMIT_MS * (`CLK_HZ / `MS_PER_S)),
  parameter logic [TW-1:0] STAB_CYCLES  =
    TW'(`STABILISATION_MS * (`CLK_HZ / `MS_PER_S))
) (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        stage_one_heat_demand_in,
  input  wire logic        stage_two_heat_demand_in,
  input  wire logic        flame_probe_in,
  input  wire logic        reset_button_in,
  output logic             spark_generator_out,
  output logic             pilot_gas_valve_out,
  output logic             gas_safety_valve_out,
  output logic             main_burner_low_out,
  output logic             main_burner_high_out,
  output logic             lockout_lamp_out,
  output logic             irq_out
);

  bis_pkg::seq_state_type state;
  bis_pkg::seq_state_type next_state;
  bis_pkg::actuator_type  drive;
  bis_pkg::actuator_type  next_drive;
  logic                   retry;
  logic                   next_retry;
  logic                   btn_prev;
  logic                   next_btn_prev;
  logic                   tmr_load;
  logic                   tmr_done;
  logic [TW-1:0]          tmr_value;
  logic                   demand;
  logic                   press;
  logic                   soft_press;

  logic [31:0]            ctrl;
  logic [31:0]            next_ctrl;
  logic [`IRQ_WIDTH-1:0]  irq_stat;
  logic [`IRQ_WIDTH-1:0]  next_irq_stat;
  logic [`IRQ_WIDTH-1:0]  irq_mask;
  logic [`IRQ_WIDTH-1:0]  next_irq_mask;
  logic [`IRQ_WIDTH-1:0]  events;
  logic                   wr_pend;
  logic                   next_wr_pend;
  logic [31:0]            wr_addr;
  logic [31:0]            next_wr_addr;
  logic [31:0]            rdata;
  logic [31:0]            next_rdata;
  logic                   accept;
  logic                   wr_now;

  // Step length minus one, so that a step lasts exactly its count
  function automatic logic [TW-1:0] step_len(input bis_pkg::seq_state_type s);
    logic [TW-1:0] len;
    len = '0;
    unique case (s)
      bis_pkg::S_WAIT:  len = WAIT_CYCLES - TW'(1);
      bis_pkg::S_SPARK: len = PREIGN_CYCLES - TW'(1);
      bis_pkg::S_PROVE: len = PROVE_CYCLES - TW'(1);
      bis_pkg::S_STAB:  len = STAB_CYCLES - TW'(1);
      bis_pkg::S_LOCK, bis_pkg::S_IDLE, bis_pkg::S_RUN: len = '0;
    endcase
    return len;
  endfunction : step_len

  // Actuator pattern of each state; spark continues until flame is proven
  function automatic bis_pkg::actuator_type act_of(input bis_pkg::seq_state_type s,
                                                   input logic hi);
    bis_pkg::actuator_type a;
    a = '0;
    unique case (s)
      bis_pkg::S_LOCK:  a.lamp = 1'b1;
      bis_pkg::S_IDLE, bis_pkg::S_WAIT: a = '0;
      bis_pkg::S_SPARK: a.spark = 1'b1;
      bis_pkg::S_PROVE: begin
        a.spark  = 1'b1;
        a.pilot  = 1'b1;
        a.safety = 1'b1;
      end
      bis_pkg::S_STAB: begin
        a.pilot  = 1'b1;
        a.safety = 1'b1;
      end
      bis_pkg::S_RUN: begin
        a.pilot  = 1'b1;
        a.safety = 1'b1;
        a.low    = 1'b1;
        a.high   = hi;
      end
    endcase
    return a;
  endfunction : act_of

  function automatic logic [31:0] reg_read(input logic [31:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      `REG_CTRL:     v = ctrl;
      `REG_STATUS:   v = (32'(state) << `STAT_STATE_LSB)
                       | (32'(retry) << `STAT_RETRY_BIT)
                       | (32'(drive) << `STAT_ACT_LSB);
      `REG_IRQ_STAT: v = 32'(irq_stat);
      `REG_IRQ_MASK: v = 32'(irq_mask);
      default:       v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  // Software may mask out demand; a written press acts like the button
  assign demand = stage_one_heat_demand_in & ctrl[`CTRL_ENABLE_BIT];
  assign press  = (reset_button_in & ~btn_prev) | soft_press;

  // Sequencer
  always_comb begin
    next_state    = state;
    next_retry    = retry;
    next_btn_prev = reset_button_in;
    unique case (state)
      bis_pkg::S_LOCK: begin
        if (press) begin
          next_state = bis_pkg::S_IDLE;
          next_retry = 1'b0;
        end
      end
      bis_pkg::S_IDLE: begin
        if (demand) begin
          next_state = bis_pkg::S_WAIT;
        end
      end
      bis_pkg::S_WAIT: begin
        if (tmr_done) begin
          next_state = bis_pkg::S_SPARK;
        end
      end
      bis_pkg::S_SPARK: begin
        if (tmr_done) begin
          next_state = bis_pkg::S_PROVE;
        end
      end
      bis_pkg::S_PROVE: begin
        if (flame_probe_in) begin
          next_state = bis_pkg::S_STAB;
        end else if (tmr_done) begin
          next_state = bis_pkg::S_LOCK;
        end
      end
      bis_pkg::S_STAB: begin
        if (!flame_probe_in) begin
          next_state = retry ? bis_pkg::S_LOCK : bis_pkg::S_WAIT;
          next_retry = 1'b1;
        end else if (tmr_done) begin
          next_state = bis_pkg::S_RUN;
          next_retry = 1'b0;
        end
      end
      bis_pkg::S_RUN: begin
        if (!flame_probe_in) begin
          next_state = bis_pkg::S_WAIT;
          next_retry = 1'b1;
        end
      end
    endcase
    // Demand loss takes priority outside lockout, manual reset outside lockout and idle
    if (state != bis_pkg::S_LOCK && !demand) begin
      next_state = bis_pkg::S_IDLE;
      next_retry = 1'b0;
    end else if (state != bis_pkg::S_LOCK && state != bis_pkg::S_IDLE && press) begin
      next_state = bis_pkg::S_WAIT;
      next_retry = 1'b0;
    end
    next_drive = act_of(next_state, stage_two_heat_demand_in);
  end

  // Power-up lands in lockout: a safe default until someone presses reset
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state    <= bis_pkg::S_LOCK;
      retry    <= 1'b0;
      btn_prev <= 1'b0;
      drive    <= bis_pkg::actuator_type'(`ACT_LOCK_RESET);
    end else begin
      state    <= next_state;
      retry    <= next_retry;
      btn_prev <= next_btn_prev;
      drive    <= next_drive;
    end
  end

  assign tmr_load  = (next_state != state);
  assign tmr_value = step_len(next_state);

  seq_timer #(
    .TW         (TW)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .load_in    (tmr_load),
    .value_in   (tmr_value),
    .done_out   (tmr_done)
  );

  assign spark_generator_out  = drive.spark;
  assign pilot_gas_valve_out  = drive.pilot;
  assign gas_safety_valve_out = drive.safety;
  assign main_burner_low_out  = drive.low;
  assign main_burner_high_out = drive.high;
  assign lockout_lamp_out     = drive.lamp;

  // Bus slave: zero wait states, writes land at the end of the data phase
  assign accept     = hsel_in & hready_in & htrans_in[1];
  assign wr_now     = wr_pend;
  assign soft_press = wr_now && (wr_addr == `REG_CTRL) && hwdata_in[`CTRL_PRESS_BIT];

  always_comb begin
    events                  = '0;
    events[`IRQ_LOCK_BIT]   = (next_state == bis_pkg::S_LOCK) && (state != bis_pkg::S_LOCK);
    events[`IRQ_LOSS_BIT]   = (state == bis_pkg::S_RUN) && !flame_probe_in && demand;
    events[`IRQ_RUN_BIT]    = (next_state == bis_pkg::S_RUN) && (state != bis_pkg::S_RUN);
    next_wr_pend  = accept & hwrite_in;
    next_wr_addr  = accept ? haddr_in : wr_addr;
    next_rdata    = (accept && !hwrite_in) ? reg_read(haddr_in) : rdata;
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_now && wr_addr == `REG_CTRL) begin
      next_ctrl = hwdata_in & `CTRL_STORED_MASK;
    end
    if (wr_now && wr_addr == `REG_IRQ_MASK) begin
      next_irq_mask = hwdata_in[`IRQ_WIDTH-1:0];
    end
    if (wr_now && wr_addr == `REG_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~hwdata_in[`IRQ_WIDTH-1:0];
    end
    // A new event wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 32'h0000_0000;
      rdata    <= 32'h0000_0000;
      ctrl     <= `CTRL_RESET;
      irq_mask <= `IRQ_RESET;
      irq_stat <= `IRQ_RESET;
    end else begin
      wr_pend  <= next_wr_pend;
      wr_addr  <= next_wr_addr;
      rdata    <= next_rdata;
      ctrl     <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
    end
  end

  assign hrdata_out    = rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign irq_out       = |(irq_stat & irq_mask);

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  a_spark_after_wait: assert property (
    (state == bis_pkg::S_WAIT) && tmr_done && demand && !press
    |=> spark_generator_out && !pilot_gas_valve_out)
    else $error("Spark did not start after waiting delay");

  a_valves_after_spark: assert property (
    (state == bis_pkg::S_SPARK) && tmr_done && demand && !press
    |=> pilot_gas_valve_out && gas_safety_valve_out && spark_generator_out)
    else $error("Valves did not open after pre-ignition delay");

  a_main_after_stab: assert property (
    (state == bis_pkg::S_STAB) && tmr_done && flame_probe_in && demand && !press
    |=> main_burner_low_out && (main_burner_high_out == $past(stage_two_heat_demand_in)))
    else $error("Main burner did not start after stabilisation");

  a_lock_on_timeout: assert property (
    (state == bis_pkg::S_PROVE) && tmr_done && !flame_probe_in && demand && !press
    |=> lockout_lamp_out && !pilot_gas_valve_out && !gas_safety_valve_out)
    else $error("No lockout after safety time without flame");

  a_lock_latched: assert property (
    (state == bis_pkg::S_LOCK) && !press
    |=> (state == bis_pkg::S_LOCK) && lockout_lamp_out)
    else $error("Lockout cleared without reset press");

  a_restart_on_loss: assert property (
    (state == bis_pkg::S_RUN) && !flame_probe_in && demand && !press
    |=> (state == bis_pkg::S_WAIT) && retry && !main_burner_low_out
        && irq_stat[`IRQ_LOSS_BIT])
    else $error("Flame loss did not restart sequence");

  a_retry_to_lock: assert property (
    (state == bis_pkg::S_STAB) && retry && !flame_probe_in && demand && !press
    |=> (state == bis_pkg::S_LOCK) && lockout_lamp_out)
    else $error("Failed restart did not lock out");

  a_release_lock: assert property (
    (state == bis_pkg::S_LOCK) && press
    |=> (state == bis_pkg::S_IDLE) && !lockout_lamp_out)
    else $error("Reset press did not release lockout");

  a_reset_restart: assert property (
    (state inside {bis_pkg::S_PROVE, bis_pkg::S_STAB, bis_pkg::S_RUN}) && press && demand
    |=> !pilot_gas_valve_out && !gas_safety_valve_out && (state == bis_pkg::S_WAIT))
    else $error("Reset during running did not restart");

  a_demand_idle: assert property (
    (state != bis_pkg::S_LOCK) && !demand
    |=> (state == bis_pkg::S_IDLE) && !spark_generator_out && !pilot_gas_valve_out
        && !gas_safety_valve_out && !main_burner_low_out)
    else $error("Demand loss did not return to idle");

  a_irq_level: assert property (
    $rose(irq_stat[`IRQ_LOCK_BIT]) && irq_mask[`IRQ_LOCK_BIT] |-> irq_out)
    else $error("Masked-in event did not raise interrupt");

endmodule : burner_ignition_sequencer

`default_nettype wire

// >>> burner_field_model.sv
// Field side model: flame probe lit by the pilot and safety valves
`timescale 1ns/100ps
`default_nettype none

module burner_field_model #(
  parameter int LIGHT_DLY = 3
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic pilot_gas_valve_in,
  input  wire logic gas_safety_valve_in,
  input  wire logic light_enable_in,
  output logic      flame_probe_out
);
  logic [7:0] age;

  // Flame needs both valves open; closing either snuffs it at once
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      age             <= 8'h00;
      flame_probe_out <= 1'b0;
    end else if (pilot_gas_valve_in && gas_safety_valve_in && light_enable_in) begin
      if (age != 8'(LIGHT_DLY)) begin
        age <= age + 8'h01;
      end
      flame_probe_out <= (age == 8'(LIGHT_DLY));
    end else begin
      age             <= 8'h00;
      flame_probe_out <= 1'b0;
    end
  end
endmodule : burner_field_model

`default_nettype wire

// >>> burner_ignition_sequencer_tb.sv
// Self-checking bench for the burner ignition sequencer
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module burner_ignition_sequencer_tb;
  localparam int WAIT = 10;
  localparam int PREIGN = 20;
  localparam int PROVE = 20;
  localparam int STAB = 10;

  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        demand1 = 1'b0;
  logic        demand2 = 1'b0;
  logic        button = 1'b0;
  logic        light_en = 1'b0;
  logic        flame;
  logic        irq;
  wire  [5:0]  act;
  logic        hresp;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;

  always #5 clk_sys_in = ~clk_sys_in;

  burner_ignition_sequencer #(
    .WAIT_CYCLES   (32'(WAIT)),
    .PREIGN_CYCLES (32'(PREIGN)),
    .PROVE_CYCLES  (32'(PROVE)),
    .STAB_CYCLES   (32'(STAB))
  ) dut_u (
    .clk_sys_in               (clk_sys_in),
    .nrst_in                  (nrst_in),
    .hsel_in                  (hsel),
    .haddr_in                 (haddr),
    .htrans_in                (htrans),
    .hwrite_in                (hwrite),
    .hsize_in                 (3'b010),
    .hwdata_in                (hwdata),
    .hready_in                (hready),
    .hrdata_out               (hrdata),
    .hreadyout_out            (hready),
    .hresp_out                (hresp),
    .stage_one_heat_demand_in (demand1),
    .stage_two_heat_demand_in (demand2),
    .flame_probe_in           (flame),
    .reset_button_in          (button),
    .spark_generator_out      (act[0]),
    .pilot_gas_valve_out      (act[1]),
    .gas_safety_valve_out     (act[2]),
    .main_burner_low_out      (act[3]),
    .main_burner_high_out     (act[4]),
    .lockout_lamp_out         (act[5]),
    .irq_out                  (irq)
  );

  burner_field_model field_u (
    .clk_sys_in          (clk_sys_in),
    .nrst_in             (nrst_in),
    .pilot_gas_valve_in  (act[1]),
    .gas_safety_valve_in (act[2]),
    .light_enable_in     (light_en),
    .flame_probe_out     (flame)
  );

  task results;
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // One single word transfer; the wait lasts as long as the slave holds hready low
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys_in);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  // Presses only follow successful releases, so no 15 s spacing is needed
  task press;
    @(posedge clk_sys_in);
    button <= 1'b1;
    @(posedge clk_sys_in);
    button <= 1'b0;
  endtask : press

  task wait_act(input int b, input logic v, output int k);
    k = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      k++;
    end while (act[b] !== v && k < 200);
  endtask : wait_act

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, q);
    `CHK(q, 32'h0000_2000)
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0001)
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    ahb(1'b1, 32'h0000_000C, 32'h0000_0007, q);
    press();
    wait_act(5, 1'b0, n);
    `CHK(act, 6'b00_0000)
    light_en <= 1'b1;
    demand2  <= 1'b1;
    @(posedge clk_sys_in);
    demand1 <= 1'b1;
    wait_act(0, 1'b1, n);
    `CHK(n, WAIT + 1)
    wait_act(1, 1'b1, n);
    `CHK(n, PREIGN)
    `CHK(act[2], 1'b1)
    wait_act(3, 1'b1, n);
    `CHK(act, 6'b01_1110)
    `CHK(irq, 1'b1)
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0004)
    ahb(1'b1, 32'h0000_0008, 32'h0000_0004, q);
    #1;
    `CHK(irq, 1'b0)
    // Flame drops in running and comes back on the restart
    light_en <= 1'b0;
    wait_act(1, 1'b0, n);
    light_en <= 1'b1;
    wait_act(0, 1'b1, n);
    `CHK(n, WAIT)
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, q);
    `CHK(q[3], 1'b1)
    wait_act(3, 1'b1, n);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0006)
    ahb(1'b1, 32'h0000_0008, 32'h0000_0006, q);
    // Flame drops again and never returns
    light_en <= 1'b0;
    wait_act(5, 1'b1, n);
    `CHK(act, 6'b10_0000)
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0003)
    demand1 <= 1'b0;
    repeat (30) @(posedge clk_sys_in);
    `CHK(act, 6'b10_0000)
    ahb(1'b1, 32'h0000_0008, 32'h0000_0007, q);
    demand1 <= 1'b1;
    press();
    wait_act(1, 1'b1, n);
    `CHK(act[5], 1'b0)
    wait_act(5, 1'b1, n);
    `CHK(n, PROVE)
    `CHK(act, 6'b10_0000)
    light_en <= 1'b1;
    press();
    wait_act(3, 1'b1, n);
    `CHK(act[5], 1'b0)
    press();
    wait_act(1, 1'b0, n);
    `CHK(act, 6'b00_0000)
    wait_act(0, 1'b1, n);
    // The restart edge falls inside the press task and the pilot-off wait takes one more edge
    `CHK(n, WAIT - 1)
    demand1 <= 1'b0;
    wait_act(0, 1'b0, n);
    `CHK(act, 6'b00_0000)
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0001)
    ahb(1'b1, 32'h0000_0000, 32'h0000_0000, q);
    demand1 <= 1'b1;
    repeat (WAIT + 5) @(posedge clk_sys_in);
    `CHK(act, 6'b00_0000)
    `CHK(hresp, 1'b0)
    // Re-enable with the press bit set: it is not stored and idle ignores it
    demand2 <= 1'b0;
    ahb(1'b1, 32'h0000_0000, 32'h0000_0003, q);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0001)
    wait_act(3, 1'b1, n);
    `CHK(act, 6'b00_1110)
    // Flame lost, relit on the restart, then lost again while stabilising
    light_en <= 1'b0;
    wait_act(1, 1'b0, n);
    light_en <= 1'b1;
    wait_act(1, 1'b1, n);
    wait_act(0, 1'b0, n);
    light_en <= 1'b0;
    wait_act(5, 1'b1, n);
    `CHK(n, 2)
    `CHK(act, 6'b10_0000)
    // A press written over the bus releases lockout like the button
    ahb(1'b1, 32'h0000_0000, 32'h0000_0003, q);
    #1;
    `CHK(act[5], 1'b0)
    results();
  end
endmodule : burner_ignition_sequencer_tb

`default_nettype wire
